// File: inc/algo_debug_pkg.sv
// shared constants and types for the algorithm debug override register
package algo_debug_pkg;
   // register map: byte offset of the debug control word
   localparam logic [7:0] ALGO_CTRL_OFFSET = 8'hEC;
   localparam logic [31:0] ALGO_CTRL_RESET = 32'h0000_0000;
   // field positions inside the control word
   localparam int OVERRIDE_BIT = 31;
   localparam int SPEED_HI = 30;
   localparam int SPEED_LO = 16;
   localparam int FEEDBACK_OFF_BIT = 15;
   localparam int HOLD_ALIGN_BIT = 14;
   localparam int HOLD_SLOW_BIT = 13;
   localparam int HOLD_POSITION_BIT = 12;
   localparam int HOLD_SPIN_BIT = 11;
   localparam int ANGLE_SRC_BIT = 10;
   localparam int TORQUE_HI = 9;
   localparam int TORQUE_LO = 0;
   // field widths
   localparam int SPEED_W = 15;
   localparam int TORQUE_CODE_W = 10;
   localparam int TORQUE_REF_W = 12;
   localparam int ANGLE_W = 9;
   // torque code ranges: positive up to 500, negative from 512 to 1000
   localparam logic [9:0] TORQUE_POS_MAX = 10'h1F4;
   localparam logic [9:0] TORQUE_NEG_BASE = 10'h200;
   localparam logic [9:0] TORQUE_NEG_MAX = 10'h3E8;
   // lock angle wraps at a full turn in degrees
   localparam logic [8:0] ANGLE_FULL_TURN = 9'h168;
   // startup method encodings
   localparam logic [1:0] METHOD_ALIGN = 2'h0;
   localparam logic [1:0] METHOD_DOUBLE_ALIGN = 2'h1;
   localparam logic [1:0] METHOD_SLOW_CYCLE = 2'h2;
   localparam logic [1:0] METHOD_POSITION = 2'h3;
   // startup sequencer stages
   typedef enum logic [2:0] {
      ST_IDLE,
      ST_SPIN_DETECT,
      ST_POSITION_DETECT,
      ST_ALIGN,
      ST_SLOW_CYCLE,
      ST_OPEN_LOOP,
      ST_CLOSED_LOOP
   } stage_t;
endpackage

// File: rtl/lock_angle_wrap.sv
// lock angle selection with the register angle wrapped to one turn, registered output
`timescale 1ns/10ps
module lock_angle_wrap
   import algo_debug_pkg::*;
(
   input wire logic clk,
   input wire logic reset,
   input wire logic use_register_angle,
   input wire logic [ANGLE_W-1:0] config_angle,
   input wire logic [ANGLE_W-1:0] register_angle,
   output logic [ANGLE_W-1:0] angle
);
   logic [ANGLE_W-1:0] angle_reg; // applied angle
   logic [ANGLE_W-1:0] angle_next;

   // register angle is reduced modulo a full turn; 9 bits never reach
   // two turns, so one subtraction is enough
   always_comb begin
      if (use_register_angle) begin
         if (register_angle >= ANGLE_FULL_TURN) begin
            angle_next = register_angle - ANGLE_FULL_TURN;
         end else begin
            angle_next = register_angle;
         end
      end else begin
         angle_next = config_angle;
      end
   end

   // plain register stage keeps the output glitch free
   always_ff @(posedge clk) begin
      if (reset) begin
         angle_reg <= '0;
      end else begin
         angle_reg <= angle_next;
      end
   end

   assign angle = angle_reg;

   chk_wrap_range: assert property (@(posedge clk) disable iff (reset)
      use_register_angle |=> angle < ANGLE_FULL_TURN)
      else $error("register lock angle not wrapped below one turn");
endmodule

// File: rtl/algo_debug_override_ctrl.sv
// write-only algorithm debug override register and the logic it steers
`timescale 1ns/10ps
module algo_debug_override_ctrl
   import algo_debug_pkg::*;
(
   input wire logic clk,
   input wire logic reset,
   // serial interface write side, already deserialised
   input wire logic wr_en,
   input wire logic [7:0] wr_addr,
   input wire logic [31:0] wr_data,
   // command and algorithm status inputs
   input wire logic [SPEED_W-1:0] analog_speed_cmd,
   input wire logic velocity_regulator_off,
   input wire logic [1:0] startup_method,
   input wire logic spin_detect_enable,
   input wire logic motor_start,
   input wire logic stage_done,
   input wire logic [ANGLE_W-1:0] config_lock_angle,
   input wire logic [ANGLE_W-1:0] forced_lock_angle,
   // outputs toward the motor algorithm
   output logic [SPEED_W-1:0] speed_command,
   output logic speed_from_register,
   output logic feedback_commutation_off,
   output stage_t startup_stage,
   output logic [ANGLE_W-1:0] lock_angle,
   output logic signed [TORQUE_REF_W-1:0] torque_current_reference,
   output logic torque_ref_active,
   output logic torque_code_invalid
);
   // true when a torque code is in one of the two legal ranges
   function automatic logic torque_code_ok(input logic [9:0] code);
      torque_code_ok = (code <= TORQUE_POS_MAX) ||
         ((code >= TORQUE_NEG_BASE) && (code <= TORQUE_NEG_MAX));
   endfunction

   // first stage after detection, chosen by the startup method
   function automatic stage_t first_stage(input logic [1:0] method);
      case (method)
         METHOD_POSITION: first_stage = ST_POSITION_DETECT;
         METHOD_SLOW_CYCLE: first_stage = ST_SLOW_CYCLE;
         default: first_stage = ST_ALIGN;
      endcase
   endfunction

   // ---------------------------------------------------------------
   // control word storage
   // ---------------------------------------------------------------
   logic [31:0] ctrl_reg; // last written control word
   logic [31:0] ctrl_next;
   logic hit; // write aimed at this register

   // a write replaces the whole word; no read path exists, so software
   // must keep its own shadow copy
   always_comb begin
      hit = wr_en && (wr_addr == ALGO_CTRL_OFFSET);
      ctrl_next = ctrl_reg;
      if (hit) begin
         ctrl_next = wr_data;
      end
   end

   // zero reset leaves every override and hold inactive
   always_ff @(posedge clk) begin
      if (reset) begin
         ctrl_reg <= ALGO_CTRL_RESET;
      end else begin
         ctrl_reg <= ctrl_next;
      end
   end

   // decoded fields
   logic override_on; // speed from register
   logic [SPEED_W-1:0] register_speed_bits; // digital speed field
   logic hold_align_stage; // keep align stage
   logic hold_slow_stage; // keep slow first cycle
   logic hold_position_detect_stage; // keep position detection
   logic hold_spin_detect_stage; // keep speed detection
   logic lock_angle_source_select; // 1: register angle
   logic [TORQUE_CODE_W-1:0] manual_torque_current_code;

   assign override_on = ctrl_reg[OVERRIDE_BIT];
   assign register_speed_bits = ctrl_reg[SPEED_HI:SPEED_LO];
   assign hold_align_stage = ctrl_reg[HOLD_ALIGN_BIT];
   assign hold_slow_stage = ctrl_reg[HOLD_SLOW_BIT];
   assign hold_position_detect_stage = ctrl_reg[HOLD_POSITION_BIT];
   assign hold_spin_detect_stage = ctrl_reg[HOLD_SPIN_BIT];
   assign lock_angle_source_select = ctrl_reg[ANGLE_SRC_BIT];
   assign manual_torque_current_code = ctrl_reg[TORQUE_HI:TORQUE_LO];

   // ---------------------------------------------------------------
   // speed command source
   // ---------------------------------------------------------------
   logic [SPEED_W-1:0] speed_reg; // selected speed command
   logic [SPEED_W-1:0] speed_next;
   logic src_reg; // 1 while register supplies speed
   logic src_next;
   logic fb_off_reg; // open loop commanded
   logic fb_off_next;

   // the digital field only reaches the command while override is set
   always_comb begin
      src_next = override_on;
      fb_off_next = ctrl_reg[FEEDBACK_OFF_BIT];
      if (override_on) begin
         speed_next = register_speed_bits;
      end else begin
         speed_next = analog_speed_cmd;
      end
   end

   // one register stage so outputs come from flip-flops
   always_ff @(posedge clk) begin
      if (reset) begin
         speed_reg <= '0;
         src_reg <= 1'b0;
         fb_off_reg <= 1'b0;
      end else begin
         speed_reg <= speed_next;
         src_reg <= src_next;
         fb_off_reg <= fb_off_next;
      end
   end

   // ---------------------------------------------------------------
   // startup sequencer
   // ---------------------------------------------------------------
   stage_t state_reg; // current startup stage
   stage_t state_next;
   logic is_align_method; // align or double align chosen

   // each hold bit only matters while its own stage is active; dropping
   // motor_start always wins so a held stage can still be stopped
   always_comb begin
      is_align_method = (startup_method == METHOD_ALIGN) ||
         (startup_method == METHOD_DOUBLE_ALIGN);
      state_next = state_reg;
      if (!motor_start) begin
         state_next = ST_IDLE;
      end else begin
         case (state_reg)
            ST_IDLE: begin
               if (spin_detect_enable) begin
                  state_next = ST_SPIN_DETECT;
               end else begin
                  state_next = first_stage(startup_method);
               end
            end
            ST_SPIN_DETECT: begin
               if (stage_done && !hold_spin_detect_stage) begin
                  state_next = first_stage(startup_method);
               end
            end
            ST_POSITION_DETECT: begin
               if (stage_done && !hold_position_detect_stage) begin
                  state_next = ST_OPEN_LOOP;
               end
            end
            ST_ALIGN: begin
               if (stage_done &&
                   !(hold_align_stage && is_align_method)) begin
                  state_next = ST_OPEN_LOOP;
               end
            end
            ST_SLOW_CYCLE: begin
               if (stage_done && !hold_slow_stage) begin
                  state_next = ST_OPEN_LOOP;
               end
            end
            ST_OPEN_LOOP: begin
               // handover to feedback is blocked while open loop forced
               if (stage_done && !fb_off_next) begin
                  state_next = ST_CLOSED_LOOP;
               end
            end
            ST_CLOSED_LOOP: begin
               if (fb_off_next) begin
                  state_next = ST_OPEN_LOOP;
               end
            end
            default: begin
               state_next = ST_IDLE;
            end
         endcase
      end
   end

   // stage register
   always_ff @(posedge clk) begin
      if (reset) begin
         state_reg <= ST_IDLE;
      end else begin
         state_reg <= state_next;
      end
   end

   // ---------------------------------------------------------------
   // torque current reference, units of 0.02 A (code/500*10 A)
   // ---------------------------------------------------------------
   logic signed [TORQUE_REF_W-1:0] torque_reg;
   logic signed [TORQUE_REF_W-1:0] torque_next;
   logic tq_active_reg; // reference in force
   logic tq_active_next;
   logic tq_bad_reg; // code outside legal ranges
   logic tq_bad_next;

   // codes between the ranges are not supposed to arrive; they give a
   // zero reference and raise the invalid flag instead of a wild value
   always_comb begin
      tq_bad_next = !torque_code_ok(manual_torque_current_code);
      tq_active_next = velocity_regulator_off;
      torque_next = '0;
      if (velocity_regulator_off && !tq_bad_next) begin
         if (manual_torque_current_code <= TORQUE_POS_MAX) begin
            torque_next = signed'({2'h0, manual_torque_current_code});
         end else begin
            torque_next = -signed'({2'h0,
               manual_torque_current_code - TORQUE_NEG_BASE});
         end
      end
   end

   // torque output stage
   always_ff @(posedge clk) begin
      if (reset) begin
         torque_reg <= '0;
         tq_active_reg <= 1'b0;
         tq_bad_reg <= 1'b0;
      end else begin
         torque_reg <= torque_next;
         tq_active_reg <= tq_active_next;
         tq_bad_reg <= tq_bad_next;
      end
   end

   // lock angle source and wrap, registered inside
   lock_angle_wrap angle_unit (
      .clk(clk),
      .reset(reset),
      .use_register_angle(lock_angle_source_select),
      .config_angle(config_lock_angle),
      .register_angle(forced_lock_angle),
      .angle(lock_angle)
   );

   // outputs
   assign speed_command = speed_reg;
   assign speed_from_register = src_reg;
   assign feedback_commutation_off = fb_off_reg;
   assign startup_stage = state_reg;
   assign torque_current_reference = torque_reg;
   assign torque_ref_active = tq_active_reg;
   assign torque_code_invalid = tq_bad_reg;

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);

   chk_reset_zero: assert property ($past(reset) |-> ctrl_reg == '0)
      else $error("control word not zero after reset");
   chk_write_holds: assert property (!hit |=> ctrl_reg == $past(ctrl_reg))
      else $error("control word changed without a write");
   chk_override_speed: assert property (
      override_on |=> speed_command == $past(register_speed_bits))
      else $error("override set but register speed not applied");
   chk_analog_speed: assert property (
      !override_on |=> speed_command == $past(analog_speed_cmd) &&
         !speed_from_register)
      else $error("override clear but analog speed not applied");
   chk_open_loop: assert property (
      feedback_commutation_off |-> startup_stage != ST_CLOSED_LOOP)
      else $error("closed loop while feedback commutation off");
   chk_align_hold: assert property (
      state_reg == ST_ALIGN && hold_align_stage && is_align_method &&
      motor_start |=> state_reg == ST_ALIGN)
      else $error("align stage left while held");
   chk_slow_hold: assert property (
      state_reg == ST_SLOW_CYCLE && hold_slow_stage && motor_start
      |=> state_reg == ST_SLOW_CYCLE)
      else $error("slow first cycle left while held");
   chk_position_hold: assert property (
      state_reg == ST_POSITION_DETECT && hold_position_detect_stage &&
      motor_start |=> state_reg == ST_POSITION_DETECT)
      else $error("position detection left while held");
   chk_spin_hold: assert property (
      state_reg == ST_SPIN_DETECT && hold_spin_detect_stage && motor_start
      |=> state_reg == ST_SPIN_DETECT)
      else $error("speed detection left while held");
   chk_angle_select: assert property (
      !lock_angle_source_select |=> lock_angle == $past(config_lock_angle))
      else $error("configured lock angle not applied");
   chk_torque_pos: assert property (
      velocity_regulator_off && manual_torque_current_code <= TORQUE_POS_MAX
      |=> torque_current_reference ==
         $signed({2'h0, $past(manual_torque_current_code)}))
      else $error("positive torque reference wrong");
   chk_torque_neg: assert property (
      velocity_regulator_off &&
      manual_torque_current_code >= TORQUE_NEG_BASE &&
      manual_torque_current_code <= TORQUE_NEG_MAX
      |=> torque_current_reference == -$signed({2'h0,
         $past(manual_torque_current_code) - TORQUE_NEG_BASE}) &&
         !torque_code_invalid)
      else $error("negative torque reference wrong");

   cov_override: cover property (hit ##1 override_on ##1 speed_from_register);
   cov_align_held: cover property (
      state_reg == ST_ALIGN && hold_align_stage && stage_done);
   cov_closed_loop: cover property (
      state_reg == ST_OPEN_LOOP ##1 state_reg == ST_CLOSED_LOOP);
   cov_torque_neg: cover property (torque_current_reference < 0);
endmodule

// File: testbench/ctrl_writer.sv
// model of the external controller that writes the debug control word
`timescale 1ns/10ps
module ctrl_writer
   import algo_debug_pkg::*;
(
   input wire logic clk,
   output logic wr_en,
   output logic [7:0] wr_addr,
   output logic [31:0] wr_data
);
   // bus is quiet at time zero
   initial begin
      wr_en = 1'b0;
      wr_addr = 8'h00;
      wr_data = 32'h0000_0000;
   end
   // true for torque codes a careful controller never sends
   function automatic logic bad_code(input logic [9:0] c);
      return (c > TORQUE_POS_MAX && c < TORQUE_NEG_BASE) ||
         (c > TORQUE_NEG_MAX);
   endfunction
   // one write: launched after an edge, held through the sampling edge
   task automatic put(input logic [7:0] addr, input logic [31:0] data,
      input logic allow_bad);
      logic [31:0] word;
      word = data;
      // only a scenario that asks for it may send a reserved code
      if (!allow_bad && bad_code(word[9:0])) begin
         word[9:0] = 10'h000;
      end
      @(posedge clk);
      wr_en <= 1'b1;
      wr_addr <= addr;
      wr_data <= word;
      @(posedge clk);
      // released bus shows the inverse, so a stale copy cannot pass
      wr_en <= 1'b0;
      wr_addr <= ~addr;
      wr_data <= ~word;
   endtask
endmodule

// File: testbench/algo_debug_override_ctrl_bench.sv
// self-checking bench for the algorithm debug override register
`timescale 1ns/10ps
module algo_debug_override_ctrl_bench
   import algo_debug_pkg::*;
   ;
   logic clk = 1'b0;
   logic reset = 1'b1;
   logic wr_en;
   logic [7:0] wr_addr;
   logic [31:0] wr_data;
   logic [SPEED_W-1:0] analog_speed_cmd = 15'h1234;
   logic velocity_regulator_off = 1'b0;
   logic [1:0] startup_method = 2'h0;
   logic spin_detect_enable = 1'b0;
   logic motor_start = 1'b0;
   logic stage_done = 1'b0;
   logic [ANGLE_W-1:0] config_lock_angle = 9'h02D;
   logic [ANGLE_W-1:0] forced_lock_angle = 9'h190;
   logic [SPEED_W-1:0] speed_command;
   logic speed_from_register;
   logic feedback_commutation_off;
   stage_t startup_stage;
   logic [ANGLE_W-1:0] lock_angle;
   logic signed [TORQUE_REF_W-1:0] torque_current_reference;
   logic torque_ref_active;
   logic torque_code_invalid;
   int num_errors = 0;
   int n_tests = 0;
   // sequencer table: method, spin enable, hold bit, stage held
   logic [1:0] meth [5] = '{2'h0, 2'h1, 2'h2, 2'h3, 2'h0};
   logic spin [5] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b1};
   int hold_bit [5] = '{14, 14, 13, 12, 11};
   stage_t held [5] = '{ST_ALIGN, ST_ALIGN, ST_SLOW_CYCLE,
      ST_POSITION_DETECT, ST_SPIN_DETECT};
   // torque codes: both range ends, then two reserved codes
   logic [9:0] codes [7] = '{10'h000, 10'h0FA, 10'h1F4, 10'h200,
      10'h3E8, 10'h1F5, 10'h3E9};

   // 50 MHz clock
   always begin
      #10 clk = ~clk;
   end

   ctrl_writer u_ctrl (.clk(clk), .wr_en(wr_en), .wr_addr(wr_addr),
      .wr_data(wr_data));

   algo_debug_override_ctrl DUT (.clk(clk), .reset(reset), .wr_en(wr_en),
      .wr_addr(wr_addr), .wr_data(wr_data),
      .analog_speed_cmd(analog_speed_cmd),
      .velocity_regulator_off(velocity_regulator_off),
      .startup_method(startup_method),
      .spin_detect_enable(spin_detect_enable), .motor_start(motor_start),
      .stage_done(stage_done), .config_lock_angle(config_lock_angle),
      .forced_lock_angle(forced_lock_angle), .speed_command(speed_command),
      .speed_from_register(speed_from_register),
      .feedback_commutation_off(feedback_commutation_off),
      .startup_stage(startup_stage), .lock_angle(lock_angle),
      .torque_current_reference(torque_current_reference),
      .torque_ref_active(torque_ref_active),
      .torque_code_invalid(torque_code_invalid));

   // counts every compare, reports a mismatch at once
   task automatic check(input logic ok, input string msg);
      n_tests++;
      if (ok !== 1'b1) begin
         num_errors++;
         $display("wrong value at %0t: %s", $time, msg);
      end
   endtask

   // write a word, then let the two-edge latency pass
   task automatic put_settle(input logic [7:0] a, input logic [31:0] d,
      input logic bad);
      u_ctrl.put(a, d, bad);
      repeat (2) @(posedge clk);
      #1;
   endtask

   // bounded wait for the sequencer to show a stage
   task automatic wait_stage(input stage_t s);
      int i;
      for (i = 0; i < 8; i++) begin
         @(posedge clk);
         #1;
         if (startup_stage === s) break;
      end
      check(startup_stage === s, "stage not reached");
   endtask

   // expected signed reference in 0.02 A steps
   function automatic logic signed [11:0] exp_torque(input logic [9:0] c);
      if (c <= 10'h1F4) return {2'b00, c};
      if (c >= 10'h200 && c <= 10'h3E8) return -{2'b00, c - 10'h200};
      return 12'h000;
   endfunction

   // verdict, the only place the run ends
   task automatic close_out();
      $display("comparisons %0d, mismatches %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   // hang guard: the tests need well under a thousand cycles
   initial begin
      repeat (5000) @(posedge clk);
      num_errors++;
      close_out();
   end

   // main sequence
   initial begin
      repeat (12) @(posedge clk);
      reset <= 1'b0;
      #1;
      // look right after the last edge that still sees reset; one edge
      // later the speed output already follows the analog input
      check(speed_command === 15'h0000 && !speed_from_register,
         "rst spd");
      check(lock_angle === 9'h000 && !torque_ref_active,
         "rst misc");
      check(feedback_commutation_off === 1'b0, "rst fb");
      check(startup_stage === ST_IDLE, "rst stage");
      // override clear: analog command wins over a full field
      put_settle(8'hEC, 32'h7FFF_0000, 1'b0);
      check(speed_command === 15'h1234, "analog speed");
      check(speed_from_register === 1'b0, "override flag off");
      put_settle(8'hEC, 32'hDA5A_0000, 1'b0);
      check(speed_command === 15'h5A5A, "register speed");
      check(speed_from_register === 1'b1, "override flag on");
      // another address must leave the word alone
      put_settle(8'hEE, 32'h0000_8000, 1'b0);
      check(speed_command === 15'h5A5A, "miss kept word");
      check(feedback_commutation_off === 1'b0, "miss wrote");
      put_settle(8'hEC, 32'h0000_8000, 1'b0);
      check(feedback_commutation_off === 1'b1, "loop off");
      check(speed_command === 15'h1234, "back to analog");
      // angle source: configured, then register angle wrapped
      check(lock_angle === 9'h02D, "config angle");
      put_settle(8'hEC, 32'h0000_0400, 1'b0);
      check(lock_angle === 9'h028, "400 wraps to 40");
      @(posedge clk);
      forced_lock_angle <= 9'h167;
      repeat (2) @(posedge clk);
      #1;
      check(lock_angle === 9'h167, "359 kept");
      // torque reference: zero while the speed loop runs
      put_settle(8'hEC, 32'h0000_00FA, 1'b0);
      check(torque_current_reference === 12'h000, "loop on");
      check(torque_ref_active === 1'b0, "ref idle");
      @(posedge clk);
      velocity_regulator_off <= 1'b1;
      for (int i = 0; i < 7; i++) begin
         put_settle(8'hEC, {22'h0, codes[i]}, i >= 5);
         check(torque_current_reference === exp_torque(codes[i]),
            "torque ref");
         check(torque_code_invalid === (i >= 5), "code flag");
         check(torque_ref_active === 1'b1, "ref active");
      end
      // each hold bit keeps its stage until cleared
      for (int i = 0; i < 5; i++) begin
         @(posedge clk);
         motor_start <= 1'b0;
         stage_done <= 1'b0;
         put_settle(8'hEC, 32'h1 << hold_bit[i], 1'b0);
         @(posedge clk);
         startup_method <= meth[i];
         spin_detect_enable <= spin[i];
         motor_start <= 1'b1;
         wait_stage(held[i]);
         @(posedge clk);
         stage_done <= 1'b1;
         repeat (6) @(posedge clk);
         #1;
         check(startup_stage === held[i], "hold lost");
         u_ctrl.put(8'hEC, 32'h0000_0000, 1'b0);
         wait_stage(ST_OPEN_LOOP);
         wait_stage(ST_CLOSED_LOOP);
      end
      // align hold bit does nothing for the slow-cycle method
      @(posedge clk);
      motor_start <= 1'b0;
      put_settle(8'hEC, 32'h0000_4000, 1'b0);
      @(posedge clk);
      startup_method <= 2'h2;
      spin_detect_enable <= 1'b0;
      motor_start <= 1'b1;
      wait_stage(ST_OPEN_LOOP);
      // loop disable drops closed loop and blocks the return
      u_ctrl.put(8'hEC, 32'h0000_8000, 1'b0);
      wait_stage(ST_OPEN_LOOP);
      repeat (4) @(posedge clk);
      #1;
      check(startup_stage === ST_OPEN_LOOP, "closed while off");
      // reset mid-run returns the word and sequencer to rest
      @(posedge clk);
      reset <= 1'b1;
      @(posedge clk);
      reset <= 1'b0;
      #1;
      check(feedback_commutation_off === 1'b0, "rst2 fb");
      check(startup_stage === ST_IDLE, "rst2 stage");
      check(torque_current_reference === 12'h000, "rst2 torque");
      close_out();
   end
endmodule
